// *** hw/pinl_top.sv ***
// Purpose: Fixed-priority interrupt, NMI and acceptance sequencing
// Assumes: Core signals insn_end at each instruction boundary
// Notes:   Reset/NMI pin and oscillator fault are asynchronous
//
// Contract
// - Daisy chain position fixes priority
// - NMI ignores global enable, needs own enables
// - NMI acceptance clears all three enables
// - NMI sources share vector FFFC, priority 14
// - NMI from pin edge, osc, flash
// - Pin reset mode holds core, FFFE
// - Selected edge sets flag, requests if enabled
// - Power-up clear returns pin to reset
// - Edge select toggle in NMI mode may fire
// - Osc fault sets flag, requests if enabled
// - Power-up clear forces LF, second osc off
// - Flash violation sets flag, requests if enabled
// - Maskable needs own and global enable
// - Watchdog interval: maskable, FFF4, priority 10
// - Acceptance takes six cycles, PC then SR
// - Highest pending priority is selected
// - Single-source flags clear on acceptance
// - SR cleared except clock bit, vector loaded
// - Return takes five cycles, SR then PC
// - Global enable in handler allows preemption
// - Vectors FFE0 to FFFE, priorities 0-15
// - Power-on reset always gives power-up clear
`timescale 1ns/10ps
module pinl_top
    import pinl_pkg::*;
#(
    parameter int          N_MASK     = pinl_pkg::NMASK,
    parameter logic [13:0] SINGLE_SRC = 14'h3FFF
) (
    input  wire logic                    core_clk,
    input  wire logic                    arst_n,
    input  wire logic [pinl_pkg::AW-1:0] reg_addr,
    input  wire logic [15:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [15:0]             reg_rdata,
    input  wire logic                    rst_nmi_pin,
    input  wire logic                    osc_fault_in,
    input  wire logic                    flash_violation,
    input  wire logic                    wdt_interval_ovf,
    input  wire logic                    wdt_expire,
    input  wire logic                    key_violation,
    input  wire logic [13:0]             periph_irq,
    input  wire logic                    insn_end,
    input  wire logic                    return_from_interrupt_req,
    input  wire logic [15:0]             pc_in,
    input  wire logic [15:0]             sr_in,
    input  wire logic [15:0]             mem_rdata,
    output logic                         stack_push,
    output logic                         stack_pop,
    output logic      [15:0]             stack_data,
    output logic                         mem_rd,
    output logic      [15:0]             mem_addr,
    output logic                         sr_load,
    output logic      [15:0]             sr_value,
    output logic                         pc_load,
    output logic      [15:0]             pc_value,
    output logic      [13:0]             irq_ack,
    output logic                         core_reset,
    output logic                         power_up_clear,
    output logic                         low_freq_crystal_lf,
    output logic                         second_crystal_osc_off
);
    import pinl_pkg::*;

    if (N_MASK != NMASK) begin : g_chk
        $error("pinl_top serves exactly fourteen maskable lines");
    end

    pinl_state_e state_reg;
    logic [4:0]  ctrl_reg;
    logic [3:0]  flag_reg;
    logic [13:0] irq_en_reg;
    logic [3:0]  sel_reg;
    logic [1:0]  sync_w;
    logic        pin_s;
    logic        osc_s;
    logic        cond_prev_reg;
    logic        pin_cond;
    logic        pin_evt;
    logic        nmi_req;
    logic        global_irq_enable;
    logic [14:0] req;
    logic        any_req;
    logic [3:0]  win_idx;
    logic        pin_reset_low;
    logic        flag_wr;
    logic        accept;

    pinl_sync #(
        .W (2)
    ) u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .async_in ({osc_fault_in, rst_nmi_pin}),
        .sync_out (sync_w)
    );
    assign pin_s = sync_w[0];
    assign osc_s = sync_w[1];

    assign pin_cond = ctrl_reg[CT_EDGE] ? ~pin_s : pin_s;
    assign pin_evt = ctrl_reg[CT_MODE] & pin_cond & ~cond_prev_reg;
    assign pin_reset_low = ~ctrl_reg[CT_MODE] & ~pin_s;
    assign global_irq_enable = sr_in[SR_GIE_BIT];
    assign flag_wr = reg_wr && reg_addr == REG_FLAGS;

    // NMI gated by own enables only
    assign nmi_req = (flag_reg[FL_PIN] & ctrl_reg[CT_PIN_EN])
                   | (flag_reg[FL_OSC] & ctrl_reg[CT_OSC_EN])
                   | (flag_reg[FL_FLASH] & ctrl_reg[CT_FLASH_EN]);

    always_comb begin
        req = '0;
        req[PRIO_NMI] = nmi_req;
        for (int i = 0; i < NMASK; i++) begin
            req[i] = periph_irq[i] & irq_en_reg[i] & global_irq_enable;
        end
        req[PRIO_WDT] = (periph_irq[PRIO_WDT] | flag_reg[FL_WDT])
                      & irq_en_reg[PRIO_WDT] & global_irq_enable;
    end

    pinl_prio_chain #(
        .N (15)
    ) u_chain (
        .req (req),
        .any (any_req),
        .idx (win_idx)
    );

    assign accept = state_reg == S_IDLE && insn_end && any_req;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cond_prev_reg <= 1'b0;
        end else begin
            cond_prev_reg <= pin_cond;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            power_up_clear <= 1'b1;
            core_reset     <= 1'b1;
        end else begin
            power_up_clear <= wdt_expire | key_violation | pin_reset_low;
            core_reset     <= power_up_clear | pin_reset_low;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_freq_crystal_lf    <= 1'b1;
            second_crystal_osc_off <= 1'b1;
        end else if (power_up_clear) begin
            low_freq_crystal_lf    <= 1'b1;
            second_crystal_osc_off <= 1'b1;
        end else if (reg_wr && reg_addr == REG_STATUS) begin
            low_freq_crystal_lf    <= reg_wdata[0];
            second_crystal_osc_off <= reg_wdata[1];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg   <= '0;
            irq_en_reg <= '0;
        end else if (power_up_clear) begin
            ctrl_reg   <= '0;
            irq_en_reg <= '0;
        end else if (state_reg == S_CLR_SR && sel_reg == PRIO_NMI) begin
            ctrl_reg[CT_PIN_EN]   <= 1'b0;
            ctrl_reg[CT_OSC_EN]   <= 1'b0;
            ctrl_reg[CT_FLASH_EN] <= 1'b0;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            ctrl_reg <= reg_wdata[4:0];
        end else if (reg_wr && reg_addr == REG_IRQ_EN) begin
            irq_en_reg <= reg_wdata[13:0];
        end
    end

    // Flags: write one to clear, set wins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (flag_wr && reg_wdata[i]) begin
                    flag_reg[i] <= 1'b0;
                end
            end
            if (state_reg == S_CLR_SR && sel_reg == PRIO_WDT) begin
                flag_reg[FL_WDT] <= 1'b0;
            end
            if (pin_evt) begin
                flag_reg[FL_PIN] <= 1'b1;
            end
            if (osc_s) begin
                flag_reg[FL_OSC] <= 1'b1;
            end
            if (flash_violation) begin
                flag_reg[FL_FLASH] <= 1'b1;
            end
            if (wdt_interval_ovf) begin
                flag_reg[FL_WDT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:   reg_rdata <= {11'h000, ctrl_reg};
                REG_FLAGS:  reg_rdata <= {12'h000, flag_reg};
                REG_IRQ_EN: reg_rdata <= {2'h0, irq_en_reg};
                REG_STATUS: reg_rdata <= {4'h0, sel_reg, state_reg, 1'b0,
                                          core_reset, second_crystal_osc_off,
                                          low_freq_crystal_lf};
                default:    reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Sequencer; outputs set on each transition
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg  <= S_RST_HOLD;
            sel_reg    <= PRIO_RESET;
            stack_push <= 1'b0;
            stack_pop  <= 1'b0;
            stack_data <= '0;
            mem_rd     <= 1'b0;
            mem_addr   <= '0;
            sr_load    <= 1'b0;
            sr_value   <= '0;
            pc_load    <= 1'b0;
            pc_value   <= '0;
            irq_ack    <= '0;
        end else begin
            stack_push <= 1'b0;
            stack_pop  <= 1'b0;
            mem_rd     <= 1'b0;
            sr_load    <= 1'b0;
            pc_load    <= 1'b0;
            irq_ack    <= '0;
            if (power_up_clear || pin_reset_low) begin
                state_reg <= S_RST_HOLD;
                sel_reg   <= PRIO_RESET;
            end else begin
                case (state_reg)
                    S_RST_HOLD: begin
                        state_reg <= S_VEC_RD;
                        mem_rd    <= 1'b1;
                        mem_addr  <= VEC_BASE + {11'h000, PRIO_RESET, 1'b0};
                    end
                    S_IDLE: begin
                        if (accept) begin
                            state_reg  <= S_PUSH_PC;
                            sel_reg    <= win_idx;
                            stack_push <= 1'b1;
                            stack_data <= pc_in;
                        end else if (return_from_interrupt_req) begin
                            state_reg <= S_RT_SR_RD;
                            stack_pop <= 1'b1;
                        end
                    end
                    S_PUSH_PC: begin
                        state_reg  <= S_PUSH_SR;
                        stack_push <= 1'b1;
                        stack_data <= sr_in;
                    end
                    S_PUSH_SR: begin
                        // clear SR but keep clock bit
                        state_reg <= S_CLR_SR;
                        sr_load   <= 1'b1;
                        sr_value  <= sr_in & SR_KEEP;
                        if (sel_reg < PRIO_NMI) begin
                            irq_ack[sel_reg] <= SINGLE_SRC[sel_reg];
                        end
                    end
                    S_CLR_SR: begin
                        state_reg <= S_VEC_RD;
                        mem_rd    <= 1'b1;
                        mem_addr  <= VEC_BASE + {11'h000, sel_reg, 1'b0};
                    end
                    S_VEC_RD: begin
                        state_reg <= S_VEC_WAIT;
                    end
                    S_VEC_WAIT: begin
                        state_reg <= S_LOAD;
                        pc_load   <= 1'b1;
                        pc_value  <= mem_rdata;
                    end
                    S_LOAD: begin
                        state_reg <= S_IDLE;
                    end
                    S_RT_SR_RD: begin
                        state_reg <= S_RT_SR;
                    end
                    S_RT_SR: begin
                        state_reg <= S_RT_PC_RD;
                        sr_load   <= 1'b1;
                        sr_value  <= mem_rdata;
                        stack_pop <= 1'b1;
                    end
                    S_RT_PC_RD: begin
                        state_reg <= S_RT_PC;
                    end
                    S_RT_PC: begin
                        state_reg <= S_RT_DONE;
                        pc_load   <= 1'b1;
                        pc_value  <= mem_rdata;
                    end
                    S_RT_DONE: begin
                        state_reg <= S_IDLE;
                    end
                    default: begin
                        state_reg <= S_IDLE;
                    end
                endcase
            end
        end
    end

    sequence s_accept_steps;
        stack_push ##1 stack_push ##1 sr_load ##1 mem_rd ##1 !pc_load ##1 pc_load;
    endsequence
    sequence s_return_from_interrupt_steps;
        ##2 sr_load && stack_pop ##1 !pc_load ##1 pc_load && state_reg == S_RT_DONE;
    endsequence

    property p_accept_six;
        @(posedge core_clk) disable iff (!arst_n)
        (accept && !wdt_expire && !key_violation && !pin_reset_low) |=> s_accept_steps;
    endproperty
    a_accept_six: assert property (p_accept_six) else $error("accept not six cycles");

    property p_return_from_interrupt_five;
        @(posedge core_clk) disable iff (!arst_n)
        (state_reg == S_RT_SR_RD && !power_up_clear && !pin_reset_low) |-> s_return_from_interrupt_steps;
    endproperty
    a_return_from_interrupt_five: assert property (p_return_from_interrupt_five) else $error("return not five cycles");

    property p_nmi_en_clr;
        @(posedge core_clk) disable iff (!arst_n)
        (state_reg == S_CLR_SR && sel_reg == PRIO_NMI && !power_up_clear)
        |=> ctrl_reg[4:2] == 3'b000;
    endproperty
    a_nmi_en_clr: assert property (p_nmi_en_clr) else $error("NMI enables kept");

    property p_vec_addr;
        @(posedge core_clk) disable iff (!arst_n)
        mem_rd |-> mem_addr == VEC_BASE + {11'h000, sel_reg, 1'b0};
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("bad vector address");

    property p_sr_clear;
        @(posedge core_clk) disable iff (!arst_n)
        (sr_load && state_reg == S_CLR_SR) |-> (sr_value & ~SR_KEEP) == 16'h0000;
    endproperty
    a_sr_clear: assert property (p_sr_clear) else $error("SR not cleared");

    property p_mask_gie;
        @(posedge core_clk) disable iff (!arst_n)
        (state_reg == S_PUSH_PC && sel_reg < PRIO_NMI) |-> $past(global_irq_enable);
    endproperty
    a_mask_gie: assert property (p_mask_gie) else $error("maskable without GLOBAL_IRQ_ENABLE");

    property p_nmi_wins;
        @(posedge core_clk) disable iff (!arst_n)
        (accept && nmi_req && !power_up_clear && !pin_reset_low)
        |=> sel_reg == PRIO_NMI;
    endproperty
    a_nmi_wins: assert property (p_nmi_wins) else $error("NMI not selected");

    property p_puc_mode;
        @(posedge core_clk) disable iff (!arst_n)
        power_up_clear |=> !ctrl_reg[CT_MODE] && core_reset;
    endproperty
    a_puc_mode: assert property (p_puc_mode) else $error("pin not in reset mode");

    property p_pin_flag;
        @(posedge core_clk) disable iff (!arst_n)
        pin_evt |=> flag_reg[FL_PIN];
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set");
endmodule

// *** hw/pinl_pkg.sv ***
// Purpose: Shared constants for the priority and NMI interrupt logic
// Assumes: 16-bit core, vector table in the top 32 bytes
// Notes:   Register indices address the plain register port
package pinl_pkg;
    localparam int          AW          = 4;
    localparam int          NMASK       = 14;
    localparam logic [15:0] VEC_BASE    = 16'hFFE0;
    localparam logic [3:0]  PRIO_RESET  = 4'hF;
    localparam logic [3:0]  PRIO_NMI    = 4'hE;
    localparam logic [3:0]  PRIO_WDT    = 4'hA;
    localparam int          SR_GIE_BIT  = 3;
    localparam logic [15:0] SR_KEEP     = 16'h0040;
    localparam int          ACCEPT_CYC  = 6;
    localparam int          RETURN_FROM_INTERRUPT_CYC    = 5;
    // Register indices
    localparam logic [3:0]  REG_CTRL    = 4'h0;
    localparam logic [3:0]  REG_FLAGS   = 4'h1;
    localparam logic [3:0]  REG_IRQ_EN  = 4'h2;
    localparam logic [3:0]  REG_STATUS  = 4'h3;
    // Control fields
    localparam int          CT_MODE     = 0;
    localparam int          CT_EDGE     = 1;
    localparam int          CT_PIN_EN   = 2;
    localparam int          CT_OSC_EN   = 3;
    localparam int          CT_FLASH_EN = 4;
    // Flag fields
    localparam int          FL_PIN      = 0;
    localparam int          FL_OSC      = 1;
    localparam int          FL_FLASH    = 2;
    localparam int          FL_WDT      = 3;
    typedef enum logic [3:0] {
        S_IDLE     = 4'h0,
        S_PUSH_PC  = 4'h1,
        S_PUSH_SR  = 4'h3,
        S_CLR_SR   = 4'h2,
        S_VEC_RD   = 4'h6,
        S_VEC_WAIT = 4'h7,
        S_LOAD     = 4'h5,
        S_RST_HOLD = 4'h4,
        S_RT_SR_RD = 4'h8,
        S_RT_SR    = 4'h9,
        S_RT_PC_RD = 4'hB,
        S_RT_PC    = 4'hA,
        S_RT_DONE  = 4'hE
    } pinl_state_e;
endpackage

// *** hw/pinl_sync.sv ***
// Purpose: Two-stage synchroniser for asynchronous inputs
// Assumes: Inputs are slow levels
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
module pinl_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// *** hw/pinl_prio_chain.sv ***
// Purpose: Fixed-priority daisy chain over request lines
// Assumes: Highest index sits nearest the core
// Notes:   Combinational; caller registers the result
`timescale 1ns/10ps
module pinl_prio_chain #(
    parameter int N = 15
) (
    input  wire logic [N-1:0]         req,
    output logic                      any,
    output logic [$clog2(N+1)-1:0]    idx
);
    logic [N:0]                    blk;
    logic [N-1:0]                  win;
    logic [N-1:0][$clog2(N+1)-1:0] acc;

    if (N < 2) begin : g_chk
        $error("pinl_prio_chain needs N of two or more");
    end

    assign blk[N] = 1'b0;
    for (genvar i = 0; i < N; i++) begin : g_chain
        assign win[i] = req[i] & ~blk[i+1];
        assign blk[i] = blk[i+1] | req[i];
        if (i == N - 1) begin : g_top
            assign acc[i] = win[i] ? ($clog2(N+1))'(i) : '0;
        end else begin : g_mid
            assign acc[i] = win[i] ? ($clog2(N+1))'(i) : acc[i+1];
        end
    end
    assign any = blk[0];
    assign idx = acc[0];
endmodule

// *** tb/pinl_core_model.sv ***
// Purpose: Core-side stack and vector memory facing the interrupt block
// Assumes: Read data answers one cycle after mem_rd or stack_pop
// Notes:   Each vector word holds the inverse of its own address
`timescale 1ns/10ps
module pinl_core_model (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        stack_push,
    input  wire logic        stack_pop,
    input  wire logic [15:0] stack_data,
    input  wire logic        mem_rd,
    input  wire logic [15:0] mem_addr,
    output logic      [15:0] mem_rdata
);
    logic [15:0] stack_mem [16];
    logic [3:0]  sp_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sp_reg    <= 4'h0;
            mem_rdata <= 16'h5A5A;
        end else if (stack_push) begin
            stack_mem[sp_reg] <= stack_data;
            sp_reg            <= sp_reg + 4'h1;
            mem_rdata         <= ~mem_rdata;
        end else if (stack_pop) begin
            mem_rdata <= stack_mem[sp_reg - 4'h1];
            sp_reg    <= sp_reg - 4'h1;
        end else if (mem_rd) begin
            mem_rdata <= ~mem_addr;
        end else begin
            // Stale data scrambled outside read cycles
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// *** tb/pinl_top_tb.sv ***
// Purpose: Self-checking bench for the priority and NMI interrupt logic
// Assumes: Core model answers stack pops and vector reads
// Notes:   Table rows cover maskable cases, hand tests the rest
`timescale 1ns/10ps
module pinl_top_tb;
    import pinl_pkg::*;
    typedef struct {
        logic [13:0] irq;
        logic [13:0] en;
        logic        global_irq_enable;
        logic        wdt;
        int          prio;
    } pinl_row_s;
    logic core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rst_nmi_pin = 1'b1;
    logic osc_fault_in = 1'b0, flash_violation = 1'b0, wdt_interval_ovf = 1'b0;
    logic wdt_expire = 1'b0, key_violation = 1'b0, insn_end = 1'b0, return_from_interrupt_req = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [13:0] periph_irq = 14'h0000;
    logic [15:0] reg_wdata = 16'h0000, pc_in = 16'h0000, sr_in = 16'h0000;
    logic [15:0] mem_rdata, reg_rdata, stack_data, mem_addr, sr_value, pc_value, got;
    logic [13:0] irq_ack;
    logic stack_push, stack_pop, mem_rd, sr_load, pc_load, core_reset, power_up_clear;
    logic low_freq_crystal_lf, second_crystal_osc_off;
    int   miscompares = 0;
    int   n_checks = 0;
    pinl_row_s rows [6] = '{
        '{14'h0001, 14'h0001, 1'b1, 1'b0, 0},
        '{14'h0088, 14'h3FFF, 1'b1, 1'b0, 7},
        '{14'h3000, 14'h3FFF, 1'b1, 1'b0, 13},
        '{14'h0000, 14'h0400, 1'b1, 1'b1, 10},
        '{14'h0020, 14'h3FFF, 1'b0, 1'b0, -1},
        '{14'h0024, 14'h3FDB, 1'b1, 1'b0, -1}
    };
    pinl_top dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rst_nmi_pin(rst_nmi_pin), .osc_fault_in(osc_fault_in),
        .flash_violation(flash_violation), .wdt_interval_ovf(wdt_interval_ovf),
        .wdt_expire(wdt_expire), .key_violation(key_violation), .periph_irq(periph_irq),
        .insn_end(insn_end), .return_from_interrupt_req(return_from_interrupt_req), .pc_in(pc_in), .sr_in(sr_in),
        .mem_rdata(mem_rdata), .stack_push(stack_push), .stack_pop(stack_pop),
        .stack_data(stack_data), .mem_rd(mem_rd), .mem_addr(mem_addr), .sr_load(sr_load),
        .sr_value(sr_value), .pc_load(pc_load), .pc_value(pc_value), .irq_ack(irq_ack),
        .core_reset(core_reset), .power_up_clear(power_up_clear),
        .low_freq_crystal_lf(low_freq_crystal_lf),
        .second_crystal_osc_off(second_crystal_osc_off));
    pinl_core_model core (.core_clk(core_clk), .arst_n(arst_n), .stack_push(stack_push),
        .stack_pop(stack_pop), .stack_data(stack_data), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata));
    always #2 core_clk = ~core_clk;
    task automatic close_out();
        if (miscompares == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        n_checks++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
            miscompares++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask
    task automatic pulse_end();
        @(posedge core_clk);
        insn_end <= 1'b1;
        @(posedge core_clk);
        insn_end <= 1'b0;
    endtask
    task automatic accept(input int prio);
        logic [15:0] va;
        logic [15:0] pc0;
        logic [15:0] sr0;
        va  = VEC_BASE + 16'(2 * prio);
        pc0 = pc_in;
        sr0 = sr_in;
        pulse_end();
        #1 chk("push_pc", pc0, stack_push ? stack_data : ~pc0);
        cyc(1);
        #1 chk("push_sr", sr0, stack_push ? stack_data : ~sr0);
        cyc(1);
        #1 chk("sr_clear", sr0 & SR_KEEP, sr_load ? sr_value : 16'hFFFF);
        chk("ack", prio < 14 ? 16'(1 << prio) : 16'h0, {2'b00, irq_ack});
        cyc(1);
        #1 chk("vec_addr", va, mem_rd ? mem_addr : ~va);
        cyc(2);
        #1 chk("vec_load", ~va, pc_load ? pc_value : va);
    endtask
    task automatic return_from_interrupt(input logic [15:0] pc0, input logic [15:0] sr0);
        @(posedge core_clk);
        return_from_interrupt_req <= 1'b1;
        @(posedge core_clk);
        return_from_interrupt_req <= 1'b0;
        #1 chk("pop_first", 16'h1, {15'h0, stack_pop});
        cyc(2);
        #1 chk("sr_restore", sr0, sr_load ? sr_value : ~sr0);
        cyc(2);
        #1 chk("pc_restore", pc0, pc_load ? pc_value : ~pc0);
    endtask
    task automatic noacc();
        int hits;
        hits = 0;
        pulse_end();
        repeat (8) begin
            #1 hits += int'(stack_push === 1'b1);
            @(posedge core_clk);
        end
        chk("no_accept", 16'h0, 16'(hits));
    endtask
    initial begin
        #20000;
        miscompares++;
        close_out();
    end
    initial begin
        cyc(1);
        #1 chk("reset_outs", 16'hF, {12'h0, core_reset, power_up_clear,
            low_freq_crystal_lf, second_crystal_osc_off});
        cyc(4);
        arst_n <= 1'b1;
        #1;
        for (int w = 0; w < 40 && mem_rd !== 1'b1; w++) #4;
        chk("rst_vec", 16'hFFFE, mem_addr);
        for (int w = 0; w < 10 && pc_load !== 1'b1; w++) #4;
        chk("rst_pc", 16'h0001, pc_value);
        chk("core_run", 16'h0, {15'h0, core_reset});
        foreach (rows[i]) begin
            wr(REG_IRQ_EN, {2'b00, rows[i].en});
            @(posedge core_clk);
            periph_irq       <= rows[i].irq;
            pc_in            <= 16'h1200 + 16'(i);
            sr_in            <= {8'h00, 4'hF, rows[i].global_irq_enable, 3'b000};
            wdt_interval_ovf <= rows[i].wdt;
            @(posedge core_clk);
            wdt_interval_ovf <= 1'b0;
            if (rows[i].prio < 0) noacc();
            else begin
                accept(rows[i].prio);
                return_from_interrupt(pc_in, sr_in);
            end
            @(posedge core_clk);
            periph_irq <= 14'h0000;
            rd(REG_FLAGS);
            chk("flags_clear", 16'h0, got);
        end
        wr(REG_CTRL, 16'h0002);
        wr(REG_CTRL, 16'h0000);
        wr(REG_CTRL, 16'h0002);
        rd(REG_FLAGS);
        chk("edge_sel_quiet", 16'h0, got);
        wr(REG_CTRL, 16'h001F);
        @(posedge core_clk);
        rst_nmi_pin <= 1'b0;
        sr_in       <= 16'h0000;
        cyc(4);
        // Pin released soon so a later clear cannot hold the core
        rst_nmi_pin <= 1'b1;
        rd(REG_FLAGS);
        chk("pin_flag", 16'h1, got);
        accept(14);
        rd(REG_CTRL);
        chk("nmi_en_clear", 16'h0003, got);
        rd(REG_FLAGS);
        chk("pin_flag_kept", 16'h1, got);
        wr(REG_FLAGS, 16'h0001);
        @(posedge core_clk);
        osc_fault_in <= 1'b1;
        cyc(4);
        osc_fault_in <= 1'b0;
        cyc(3);
        rd(REG_FLAGS);
        chk("osc_flag", 16'h2, got);
        noacc();
        wr(REG_FLAGS, 16'h0002);
        // Flash enable set again only once the handler is over
        wr(REG_CTRL, 16'h0013);
        wr(REG_IRQ_EN, 16'h2000);
        @(posedge core_clk);
        periph_irq      <= 14'h2000;
        sr_in           <= 16'h0008;
        flash_violation <= 1'b1;
        @(posedge core_clk);
        flash_violation <= 1'b0;
        accept(14);
        wr(REG_FLAGS, 16'h0004);
        accept(13);
        @(posedge core_clk);
        periph_irq <= 14'h0000;
        rd(4'hC);
        chk("unmapped", 16'h0, got);
        wr(REG_STATUS, 16'h0000);
        #1 chk("osc_ctl", 16'h0, {14'h0, low_freq_crystal_lf, second_crystal_osc_off});
        @(posedge core_clk);
        wdt_expire <= 1'b1;
        @(posedge core_clk);
        wdt_expire <= 1'b0;
        #1 chk("puc", 16'h1, {15'h0, power_up_clear});
        cyc(3);
        #1 chk("puc_osc", 16'h3, {14'h0, low_freq_crystal_lf, second_crystal_osc_off});
        rd(REG_CTRL);
        chk("puc_ctrl", 16'h0, got);
        @(posedge core_clk);
        rst_nmi_pin <= 1'b0;
        cyc(4);
        #1 chk("pin_hold", 16'h3, {14'h0, core_reset, power_up_clear});
        close_out();
    end
endmodule
